// [src/dmm_pkg.sv]
package dmm_pkg;
    localparam int DMM_RAM_BYTES = 256;
    localparam int DMM_LOW_BYTES = 128;
    localparam int DMM_BANK_COUNT = 4;
    localparam int DMM_BANK_REGS = 8;
    localparam logic [7:0] DMM_BIT_BASE = 8'h20;
    localparam logic [7:0] DMM_BIT_END = 8'h2f;
    localparam int DMM_FLASH_BYTES = 8192;
    localparam int DMM_SECTOR_BYTES = 512;
    localparam logic [7:0] DMM_RAM_RESET = 8'h00;
    localparam logic [7:0] DMM_FLASH_ERASED = 8'hff;

    typedef enum logic [1:0] {
        DMM_MODE_DIRECT = 2'b00,
        DMM_MODE_INDIRECT = 2'b01,
        DMM_MODE_BANKREG = 2'b10,
        DMM_MODE_BIT = 2'b11
    } dmm_mode_e;

    typedef struct packed {
        logic valid;
        logic write;
        dmm_mode_e mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmm_req_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } dmm_sfr_s;

    typedef enum logic [1:0] {
        DMM_FL_IDLE = 2'b00,
        DMM_FL_ERASE = 2'b01
    } dmm_fl_state_e;
endpackage

// [src/dmm_data_memory_map.sv]
// What this block does
// - 256 bytes data RAM; upper 128 addresses reach RAM or SFR space.
// - Indirect access to upper 128 addresses reads or writes RAM.
// - Direct access to upper 128 addresses goes to SFR space.
// - Lower 128 bytes reached by direct and indirect, same storage.
// - First 32 bytes form four banks of working registers.
// - Next 16 bytes accessible as whole bytes or single bits.
// - 8 kB flash, in-system reprogrammed in 512-byte sectors.
`timescale 1ns/1ps
module dmm_data_memory_map
    import dmm_pkg::*;
#(
    parameter int RAM_BYTES = DMM_RAM_BYTES,
    parameter int FLASH_BYTES = DMM_FLASH_BYTES,
    parameter int SECTOR_BYTES = DMM_SECTOR_BYTES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire dmm_req_s req_in,
    input wire logic [1:0] bank_sel_in,
    input wire logic [7:0] sfr_rdata_in,
    output dmm_sfr_s sfr_out,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    input wire logic fl_rd_in,
    input wire logic fl_wr_in,
    input wire logic fl_erase_in,
    input wire logic [12:0] fl_addr_in,
    input wire logic [7:0] fl_wdata_in,
    output logic [7:0] fl_rdata_out,
    output logic fl_busy_out
);
    localparam int FL_AW = $clog2(FLASH_BYTES);
    localparam int SEC_AW = $clog2(SECTOR_BYTES);

    // Decode is hard-wired for an 8-bit data address and a 13-bit flash address
    initial begin
        if (RAM_BYTES != DMM_RAM_BYTES || 2 * DMM_LOW_BYTES != RAM_BYTES) begin
            $error("dmm_data_memory_map: RAM_BYTES must be 256, split in two halves");
        end
        if (FLASH_BYTES != DMM_FLASH_BYTES || FL_AW != 13) begin
            $error("dmm_data_memory_map: FLASH_BYTES must match the 13-bit address");
        end
        // Sector and offset are concatenated, so the sector must be a power of two
        if (SECTOR_BYTES < 2 || (1 << SEC_AW) != SECTOR_BYTES) begin
            $error("dmm_data_memory_map: SECTOR_BYTES must be a power of two");
        end
        if ((FLASH_BYTES % SECTOR_BYTES) != 0) begin
            $error("dmm_data_memory_map: sectors must tile the flash");
        end
        if (DMM_BANK_COUNT != 2 ** $bits(bank_sel_in)) begin
            $error("dmm_data_memory_map: bank count must match the bank select width");
        end
        // Package layout checks
        if (DMM_BANK_COUNT * DMM_BANK_REGS != int'(DMM_BIT_BASE)) begin
            $error("dmm_data_memory_map: bit bytes must follow the register banks");
        end
        if (int'(DMM_BIT_END) - int'(DMM_BIT_BASE) + 1 != DMM_LOW_BYTES / 8) begin
            $error("dmm_data_memory_map: bit bytes must hold one bit per bit number");
        end
    end

    logic [7:0] ram_r [RAM_BYTES];
    logic [7:0] flash_r [FLASH_BYTES];

    // Bit mode: addr[6:0] is a bit number, addr[2:0] the bit in its byte
    function automatic logic [7:0] bit_byte(input logic [7:0] a);
        return DMM_BIT_BASE + {4'h0, a[6:3]};
    endfunction

    // Bank n starts at n times the bank size
    function automatic logic [7:0] bank_base(input logic [1:0] bank);
        return 8'(bank) * 8'(DMM_BANK_REGS);
    endfunction

    // Read-modify-write of one bit; the other seven bits keep their value
    function automatic logic [7:0] bit_put(input logic [7:0] old, input logic [2:0] idx,
                                           input logic val);
        logic [7:0] mask;
        mask = 8'h01 << idx;
        return val ? (old | mask) : (old & ~mask);
    endfunction

    wire logic mode_dir_w = req_in.mode == DMM_MODE_DIRECT;
    wire logic mode_bank_w = req_in.mode == DMM_MODE_BANKREG;
    wire logic mode_bit_w = req_in.mode == DMM_MODE_BIT;

    wire logic upper_w = req_in.addr[7];
    // Bank register: addr[2:0] is register number within selected bank
    wire logic [7:0] bank_addr_w = bank_base(bank_sel_in)
                                   + {5'h00, req_in.addr[2:0]};
    wire logic [7:0] bit_addr_w = bit_byte(req_in.addr);
    // Bit numbers from 128 up name bits of SFR space, which sits outside; dropped
    wire logic bit_ok_w = ~upper_w;
    // Only a direct access to the upper half leaves RAM; all else stays inside
    wire logic to_sfr_w = req_in.valid && mode_dir_w && upper_w;
    wire logic to_ram_w = req_in.valid && !to_sfr_w
                          && (!mode_bit_w || bit_ok_w);
    wire logic ram_wr_w = to_ram_w && req_in.write;
    wire logic ram_rd_w = to_ram_w && !req_in.write;
    wire logic sfr_rd_w = to_sfr_w && !req_in.write;
    wire logic [7:0] ram_addr_w = mode_bank_w ? bank_addr_w
                                : mode_bit_w ? bit_addr_w
                                : req_in.addr;
    wire logic [7:0] ram_old_w = ram_r[ram_addr_w];
    wire logic [2:0] bit_idx_w = req_in.addr[2:0];
    wire logic [7:0] bit_new_w = bit_put(ram_old_w, bit_idx_w, req_in.wdata[0]);
    wire logic [7:0] ram_wval_w = mode_bit_w ? bit_new_w : req_in.wdata;
    wire logic [7:0] ram_rval_w = mode_bit_w ? {7'h00, ram_old_w[bit_idx_w]} : ram_old_w;

    // SFR space is outside; pass the request through combinationally
    // Fields other than valid follow the request always; the far side qualifies them
    always_comb begin
        sfr_out.valid = to_sfr_w;
        sfr_out.write = req_in.write;
        sfr_out.addr = req_in.addr[6:0];
        sfr_out.wdata = req_in.wdata;
    end

    logic sfr_pend_r;
    // Loads every cycle; only ram_pend_r decides whether it is used
    logic [7:0] ram_rd_r;
    logic ram_pend_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_pend_r <= 1'b0;
            ram_pend_r <= 1'b0;
            ram_rd_r <= DMM_RAM_RESET;
        end else begin
            sfr_pend_r <= sfr_rd_w;
            ram_pend_r <= ram_rd_w;
            ram_rd_r <= ram_rval_w;
        end
    end

    // RAM contents are not reset, as real data RAM keeps no defined value
    always_ff @(posedge clk_in) begin
        if (ram_wr_w) begin
            ram_r[ram_addr_w] <= ram_wval_w;
        end
    end

    // Only one pend can be set per cycle, as a request goes either way
    wire logic rd_load_w = sfr_pend_r || ram_pend_r;
    wire logic [7:0] rd_next_w = sfr_pend_r ? sfr_rdata_in : ram_rd_r;

    // SFR read data is taken one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= DMM_RAM_RESET;
        end else if (rd_load_w) begin
            rdata_out <= rd_next_w;
        end
    end

    // Marks rdata_out new for exactly one cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_load_w;
        end
    end

    // Flash: sector erase walks one byte per cycle; writes only clear bits
    dmm_fl_state_e fl_state_r;
    logic [SEC_AW-1:0] fl_cnt_r;
    logic [FL_AW-SEC_AW-1:0] fl_sec_r;
    wire logic fl_idle_w = fl_state_r == DMM_FL_IDLE;
    wire logic [FL_AW-1:0] fl_erase_addr_w = {fl_sec_r, fl_cnt_r};
    wire logic fl_last_w = fl_cnt_r == SEC_AW'(SECTOR_BYTES - 1);
    // Strobes count only while idle; an erase beats a write in the same cycle
    wire logic fl_erase_go_w = fl_idle_w && fl_erase_in;
    wire logic fl_wr_go_w = fl_idle_w && fl_wr_in && !fl_erase_in;
    wire logic fl_rd_go_w = fl_idle_w && fl_rd_in;
    wire logic [7:0] fl_cell_w = flash_r[fl_addr_in];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fl_state_r <= DMM_FL_IDLE;
            fl_cnt_r <= '0;
            fl_sec_r <= '0;
        end else begin
            case (fl_state_r)
                DMM_FL_IDLE: begin
                    if (fl_erase_go_w) begin
                        fl_state_r <= DMM_FL_ERASE;
                        fl_sec_r <= fl_addr_in[FL_AW-1:SEC_AW];
                        fl_cnt_r <= '0;
                    end
                end
                DMM_FL_ERASE: begin
                    fl_cnt_r <= fl_cnt_r + 1'b1;
                    if (fl_last_w) begin
                        fl_state_r <= DMM_FL_IDLE;
                    end
                end
                // Unused code points fall back to idle
                default: fl_state_r <= DMM_FL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (fl_state_r == DMM_FL_ERASE) begin
            flash_r[fl_erase_addr_w] <= DMM_FLASH_ERASED;
        end else if (fl_wr_go_w) begin
            // A cell write can only clear bits; ones come back by erase alone
            flash_r[fl_addr_in] <= fl_cell_w & fl_wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fl_rdata_out <= DMM_FLASH_ERASED;
        end else if (fl_rd_go_w) begin
            fl_rdata_out <= fl_cell_w;
        end
    end

    assign fl_busy_out = !fl_idle_w;
endmodule

// [sim/dmm_monitor.sv]
`timescale 1ns/1ps
module dmm_monitor import dmm_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire dmm_req_s req_in,
    input wire dmm_sfr_s sfr_out,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic fl_busy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire up = req_in.valid && req_in.addr[7];
    wire bm = req_in.mode == DMM_MODE_BIT;
    wire rd = req_in.valid && !req_in.write && !(bm && up);
    dir_sfr_a: assert property (req_in.mode == DMM_MODE_DIRECT && up |-> sfr_out.valid)
        else $error("sfr route");
    sfr_data_a: assert property (sfr_out.valid |-> sfr_out.addr == req_in.addr[6:0])
        else $error("sfr address");
    ind_ram_a: assert property (req_in.mode == DMM_MODE_INDIRECT |-> !sfr_out.valid)
        else $error("indirect to sfr");
    low_ram_a: assert property (!up |-> !sfr_out.valid)
        else $error("low to sfr");
    rd_ans_a: assert property (rd |-> ##2 rvalid_out)
        else $error("no answer");
    no_ans_a: assert property (!rd |-> ##2 !rvalid_out)
        else $error("stray answer");
    bit_rd_a: assert property (rd && bm |-> ##2 rdata_out[7:1] == 7'h00)
        else $error("bit read");
    // Erase is too long for a delay, so busy cycles are counted here
    logic [9:0] busy_cnt_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_cnt_r <= 10'h000;
        end else if (fl_busy_out) begin
            busy_cnt_r <= busy_cnt_r + 10'h001;
        end else begin
            busy_cnt_r <= 10'h000;
        end
    end
    erase_len_a: assert property (fl_busy_out |-> busy_cnt_r < 10'(DMM_SECTOR_BYTES))
        else $error("erase too long");
    erase_end_a: assert property ($fell(fl_busy_out) |-> busy_cnt_r == 10'(DMM_SECTOR_BYTES))
        else $error("erase length");
endmodule
bind dmm_data_memory_map dmm_monitor mon (.*);

// [sim/dmm_sfr_model.sv]
`timescale 1ns/1ps
module dmm_sfr_model import dmm_pkg::*; (
    input wire logic clk_in,
    input wire dmm_sfr_s sfr_in,
    output logic [7:0] sfr_rdata_out
);
    logic [7:0] regs_r [128];
    always_ff @(posedge clk_in) begin
        if (sfr_in.valid && sfr_in.write)
            regs_r[sfr_in.addr] <= sfr_in.wdata;
        // Idle bus flips so a stale sample never matches
        sfr_rdata_out <= (sfr_in.valid && !sfr_in.write) ? regs_r[sfr_in.addr] : ~sfr_rdata_out;
    end
endmodule

// [sim/test_data_memory_address_map.sv]
`timescale 1ns/1ps
module test_data_memory_address_map import dmm_pkg::*;;
    logic clk_in = 0, rst_in = 1, fl_rd_in = 0, fl_wr_in = 0, fl_erase_in = 0, fl_busy_out, rvalid_out;
    dmm_req_s req_in = '0;
    dmm_sfr_s sfr_out;
    logic [1:0] bank_sel_in = 0;
    logic [12:0] fl_addr_in = 0;
    logic [7:0] fl_wdata_in = 0, sfr_rdata_in, rdata_out, fl_rdata_out, a, b;
    logic [15:0] lf = 16'h30a1;
    logic [7:0] exp_q[$];
    int fails = 0, checks_done = 0;
    dmm_data_memory_map uut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .req_in(req_in),
        .bank_sel_in(bank_sel_in),
        .sfr_rdata_in(sfr_rdata_in),
        .sfr_out(sfr_out),
        .rdata_out(rdata_out),
        .rvalid_out(rvalid_out),
        .fl_rd_in(fl_rd_in),
        .fl_wr_in(fl_wr_in),
        .fl_erase_in(fl_erase_in),
        .fl_addr_in(fl_addr_in),
        .fl_wdata_in(fl_wdata_in),
        .fl_rdata_out(fl_rdata_out),
        .fl_busy_out(fl_busy_out)
    );
    dmm_sfr_model sfr_m (.clk_in(clk_in), .sfr_in(sfr_out), .sfr_rdata_out(sfr_rdata_in));
    initial forever #2.5 clk_in = ~clk_in;
    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task op(logic w, dmm_mode_e m, logic [7:0] ad, d, e);
        @(posedge clk_in);
        req_in <= '{1'b1, w, m, ad, d};
        if (!w) exp_q.push_back(e);
    endtask
    task fop(logic [2:0] s, logic [12:0] ad, logic [7:0] d);
        @(posedge clk_in);
        {fl_rd_in, fl_wr_in, fl_erase_in, fl_addr_in, fl_wdata_in} <= {s, ad, d};
        @(posedge clk_in);
        {fl_rd_in, fl_wr_in, fl_erase_in} <= 3'b000;
    endtask
    always @(posedge clk_in) begin
        if (rvalid_out) begin
            if (exp_q.size() == 0) begin
                chk("stray rvalid", 8'h01, 8'h00);
            end else begin
                chk("rdata", rdata_out, exp_q.pop_front());
            end
        end
    end
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 0;
        lf = nx(lf);
        a = lf[7:0];
        b = ~a;
        op(1, DMM_MODE_INDIRECT, 8'h90, a, 0);
        op(1, DMM_MODE_DIRECT, 8'h90, b, 0);
        op(0, DMM_MODE_INDIRECT, 8'h90, 0, a);
        op(0, DMM_MODE_DIRECT, 8'h90, 0, b);
        op(1, DMM_MODE_DIRECT, 8'h45, a, 0);
        op(0, DMM_MODE_INDIRECT, 8'h45, 0, a);
        for (int i = 0; i < 4; i++) begin
            bank_sel_in <= i[1:0];
            op(1, DMM_MODE_BANKREG, 8'h07, b ^ i[7:0], 0);
            op(0, DMM_MODE_DIRECT, 8'(i * 8 + 7), 0, b ^ i[7:0]);
        end
        op(1, DMM_MODE_DIRECT, 8'h21, 8'h00, 0);
        op(1, DMM_MODE_BIT, 8'h0b, 8'h01, 0);
        op(1, DMM_MODE_BIT, 8'h8c, 8'h01, 0);
        op(0, DMM_MODE_BIT, 8'h0b, 0, 8'h01);
        op(0, DMM_MODE_DIRECT, 8'h21, 0, 8'h08);
        @(posedge clk_in);
        // Refused bit read: no answer may follow
        req_in <= '{1'b1, 1'b0, DMM_MODE_BIT, 8'h8b, 8'h00};
        @(posedge clk_in);
        req_in <= '0;
        // Unwritten byte reads unknown, so a missed read after erase shows
        fop(3'b100, 13'h0205, 0);
        fop(3'b001, 13'h0300, 0);
        // Write while busy is ignored
        fop(3'b010, 13'h0205, 0);
        repeat (DMM_SECTOR_BYTES - 3) @(posedge clk_in);
        #1 chk("busy", {7'h00, fl_busy_out}, 8'h01);
        @(posedge clk_in);
        #1 chk("idle", {7'h00, fl_busy_out}, 8'h00);
        fop(3'b100, 13'h0205, 0);
        #1 chk("erased", fl_rdata_out, 8'hff);
        fop(3'b100, 13'h03ff, 0);
        #1 chk("sector end", fl_rdata_out, 8'hff);
        fop(3'b010, 13'h0205, a);
        fop(3'b100, 13'h0205, 0);
        #1 chk("flash", fl_rdata_out, a);
        fop(3'b010, 13'h0205, b);
        fop(3'b100, 13'h0205, 0);
        #1 chk("flash and", fl_rdata_out, a & b);
        repeat (4) @(posedge clk_in);
        chk("pending", 8'(exp_q.size()), 8'h00);
        give_verdict;
    end
    initial begin
        #20000;
        fails++;
        give_verdict;
    end
endmodule
